// ===== common/clk_cfg_defs.svh
`ifndef CLK_CFG_DEFS_SVH
`define CLK_CFG_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_TRIM      8'h00
`define OFS_MDIV      8'h04
`define OFS_ACTL      8'h08
`define OFS_AFBD      8'h0C
`define OFS_ADIV      8'h10
`define OFS_ISTS      8'h14
`define OFS_IMSK      8'h18
// ****************************************
// field positions
// ****************************************
`define POS_TRIM      0
`define POS_MAIN_VCO_OUT_DIVSEL    8
`define POS_POST1     4
`define POS_POST2     0
`define POS_AEN       15
`define POS_ALOCK     14
`define POS_FSEL      8
`define POS_APRE      0
`define POS_AFBD      0
`define IRQ_LOCK_GAIN 0
`define IRQ_LOCK_LOSS 1
// ****************************************
// reset values and prescale limit
// ****************************************
`define RST_TRIM      6'h00
`define RST_MAIN_VCO_OUT_DIVSEL    2'h0
`define RST_POST1     3'h4
`define RST_POST2     3'h1
`define RST_APRE      4'h1
`define RST_AFBD      8'h96
`define PRE_MAX       4'h8
// ****************************************
// bus answers
// ****************************************
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ===== common/clk_cfg_pkg.sv
`default_nettype none
package clk_cfg_pkg;
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_e;
  typedef struct packed {
    logic [5:0]  trim_code;
    logic [1:0]  main_vco_out_divsel;
    logic [2:0]  main_post_ratio_first;
    logic [2:0]  main_post_ratio_second;
    logic        aux_loop_enable;
    logic        aux_source_select;
    logic [3:0]  aux_input_prescale;
    logic [7:0]  aux_feedback_ratio;
    logic [1:0]  aux_vco_out_divsel;
    logic [2:0]  aux_post_ratio_first;
    logic [2:0]  aux_post_ratio_second;
    logic        lock_seen;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    wr_state_e   wr_state;
    rd_state_e   rd_state;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic [1:0]  b_resp;
    logic [15:0] r_data;
    logic [1:0]  r_resp;
  } state_s;
endpackage : clk_cfg_pkg
`default_nettype wire

// ===== core/clk_cfg_regs.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`include "clk_cfg_defs.svh"
`default_nettype none
// Operation
// - trim code is a signed six-bit value, zero is centre, steps of about 0.047%.
// - code 011111 is the largest upward step, 100000 the largest downward.
// - main vco divider select: 11 full, 10 half, 01 third, 00 quarter.
// - main post ratios reset to 4 and 1.
// - aux enable set takes output from post chain, clear bypasses input clock.
// - aux lock status reads one while the aux loop is locked.
// - aux source select picks internal fast oscillator when one, primary when zero.
// - aux prescale divides by 1..8 for codes 1..8, others reserved, reset 1.
// - aux loop only starts when enabled and a peripheral requests a clock.
// - aux feedback ratio resets to 150.
// - aux vco divider select: 11 full, 10 half, 01 third, 00 quarter.
// - aux post ratios reset to 4 and 1.
// - unimplemented bits read zero; aux control bits 5-4 stay zero.
module clk_cfg_regs (
  input  wire logic              aclk,                   // bus and register clock
  input  wire logic              aresetn,                // sync reset, active low
  input  wire logic [7:0]        awaddr,                 // write address
  input  wire logic              awvalid,                // write address valid
  output logic                   awready,                // write address ready
  input  wire logic [31:0]       wdata,                  // write data
  input  wire logic [3:0]        wstrb,                  // write byte strobes
  input  wire logic              wvalid,                 // write data valid
  output logic                   wready,                 // write data ready
  output logic [1:0]             bresp,                  // write response
  output logic                   bvalid,                 // write response valid
  input  wire logic              bready,                 // write response ready
  input  wire logic [7:0]        araddr,                 // read address
  input  wire logic              arvalid,                // read address valid
  output logic                   arready,                // read address ready
  output logic [31:0]            rdata,                  // read data
  output logic [1:0]             rresp,                  // read response
  output logic                   rvalid,                 // read data valid
  input  wire logic              rready,                 // read data ready
  input  wire logic              fast_osc_clk,           // internal fast oscillator
  input  wire logic              primary_osc_clk,        // primary oscillator
  input  wire logic              aux_post_div_clk,       // aux post-divider output
  input  wire logic              periph_clk_req,         // some peripheral wants aux clock
  input  wire logic              aux_lock_in,            // aux loop lock from analog
  output logic signed [5:0]      rc_trim_code,           // oscillator trim, signed
  output logic [1:0]             main_vco_out_divsel,    // main vco divider select
  output logic [2:0]             main_vco_divisor,       // decoded main vco divisor
  output logic [2:0]             main_post_ratio_first,  // main first post ratio
  output logic [2:0]             main_post_ratio_second, // main second post ratio
  output logic [7:0]             main_out_divider,       // main total output division
  output logic                   aux_loop_enable,        // aux loop selected over bypass
  output logic                   aux_loop_run,           // aux loop start request
  output logic                   aux_source_select,      // aux input source select
  output logic [3:0]             aux_input_prescale,     // aux prescale code
  output logic                   aux_prescale_reserved,  // prescale code is reserved
  output logic [7:0]             aux_feedback_ratio,     // aux feedback multiplier
  output logic [1:0]             aux_vco_out_divsel,     // aux vco divider select
  output logic [2:0]             aux_post_ratio_first,   // aux first post ratio
  output logic [2:0]             aux_post_ratio_second,  // aux second post ratio
  output logic [10:0]            aux_out_divider,        // aux total division
  output logic                   aux_input_clock,        // selected aux input clock
  output logic                   aux_loop_output_clock,  // aux output clock
  output logic                   irq                     // level interrupt
);

  // ****************************************
  // helpers
  // ****************************************

  // vco divider decode, shared by both loops
  function automatic logic [2:0] vco_div(input logic [1:0] sel);
    vco_div = 3'h4 - {1'b0, sel};
  endfunction : vco_div

  // reserved prescale codes fall back to divide by one
  function automatic logic [3:0] pre_div(input logic [3:0] code);
    pre_div = (code == 4'h0 || code > `PRE_MAX) ? 4'h1 : code;
  endfunction : pre_div

  // address decode used by both channels
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_TRIM) || (a == `OFS_MDIV) || (a == `OFS_ACTL) ||
             (a == `OFS_AFBD) || (a == `OFS_ADIV) || (a == `OFS_ISTS) ||
             (a == `OFS_IMSK);
  endfunction : mapped

  // register image; all unlisted bits read zero
  function automatic logic [15:0] reg_value(input clk_cfg_pkg::state_s s,
                                            input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      `OFS_TRIM: v[`POS_TRIM +: 6] = s.trim_code;
      `OFS_MDIV: begin
        v[`POS_MAIN_VCO_OUT_DIVSEL +: 2] = s.main_vco_out_divsel;
        v[`POS_POST1 +: 3]  = s.main_post_ratio_first;
        v[`POS_POST2 +: 3]  = s.main_post_ratio_second;
      end
      `OFS_ACTL: begin
        v[`POS_AEN]        = s.aux_loop_enable;
        v[`POS_ALOCK]      = s.lock_seen;
        v[`POS_FSEL]       = s.aux_source_select;
        v[`POS_APRE +: 4]  = s.aux_input_prescale;
      end
      `OFS_AFBD: v[`POS_AFBD +: 8] = s.aux_feedback_ratio;
      `OFS_ADIV: begin
        v[`POS_MAIN_VCO_OUT_DIVSEL +: 2] = s.aux_vco_out_divsel;
        v[`POS_POST1 +: 3]  = s.aux_post_ratio_first;
        v[`POS_POST2 +: 3]  = s.aux_post_ratio_second;
      end
      `OFS_ISTS: v[1:0] = s.irq_status;
      `OFS_IMSK: v[1:0] = s.irq_mask;
      default:   v = 16'h0000;
    endcase
    return v;
  endfunction : reg_value

  // byte-lane merge of a write into the current image
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic [1:0]  strb);
    merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // ****************************************
  // state
  // ****************************************

  localparam clk_cfg_pkg::state_s RST_STATE = '{
    trim_code:              `RST_TRIM,
    main_vco_out_divsel:    `RST_MAIN_VCO_OUT_DIVSEL,
    main_post_ratio_first:  `RST_POST1,
    main_post_ratio_second: `RST_POST2,
    aux_loop_enable:        1'b0,
    aux_source_select:      1'b0,
    aux_input_prescale:     `RST_APRE,
    aux_feedback_ratio:     `RST_AFBD,
    aux_vco_out_divsel:     `RST_MAIN_VCO_OUT_DIVSEL,
    aux_post_ratio_first:   `RST_POST1,
    aux_post_ratio_second:  `RST_POST2,
    lock_seen:              1'b0,
    irq_status:             2'h0,
    irq_mask:               2'h0,
    wr_state:               clk_cfg_pkg::WR_IDLE,
    rd_state:               clk_cfg_pkg::RD_IDLE,
    aw_held:                1'b0,
    aw_addr:                8'h00,
    w_held:                 1'b0,
    w_data:                 16'h0000,
    w_strb:                 2'h0,
    b_resp:                 `RESP_OKAY,
    r_data:                 16'h0000,
    r_resp:                 `RESP_OKAY
  };

  clk_cfg_pkg::state_s state_reg;
  clk_cfg_pkg::state_s state_next;
  logic [7:0]          wr_addr;
  logic [15:0]         wr_val;
  logic [1:0]          irq_clear;
  logic [1:0]          irq_set;

  // handshake readies straight from state, no wait cycles
  assign awready = (state_reg.wr_state == clk_cfg_pkg::WR_IDLE) && !state_reg.aw_held;
  assign wready  = (state_reg.wr_state == clk_cfg_pkg::WR_IDLE) && !state_reg.w_held;
  assign arready = (state_reg.rd_state == clk_cfg_pkg::RD_IDLE);
  assign bvalid  = (state_reg.wr_state == clk_cfg_pkg::WR_RESP);
  assign rvalid  = (state_reg.rd_state == clk_cfg_pkg::RD_DATA);
  assign bresp   = state_reg.b_resp;
  assign rresp   = state_reg.r_resp;
  assign rdata   = {16'h0000, state_reg.r_data};

  // ****************************************
  // next state
  // ****************************************

  // address and data may arrive in either order; each is parked until both exist
  always_comb begin
    state_next = state_reg;
    irq_clear  = 2'h0;
    wr_addr    = state_reg.aw_held ? state_reg.aw_addr : awaddr;
    wr_val     = 16'h0000;
    if (awvalid && awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = wdata[15:0];
      state_next.w_strb = wstrb[1:0];
    end
    if (state_reg.wr_state == clk_cfg_pkg::WR_IDLE && state_next.aw_held &&
        state_next.w_held) begin
      wr_val = merge(reg_value(state_reg, wr_addr), state_next.w_data,
                     state_next.w_strb);
      state_next.aw_held  = 1'b0;
      state_next.w_held   = 1'b0;
      state_next.wr_state = clk_cfg_pkg::WR_RESP;
      state_next.b_resp   = mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (wr_addr)
        `OFS_TRIM: state_next.trim_code = wr_val[`POS_TRIM +: 6];
        `OFS_MDIV: begin
          state_next.main_vco_out_divsel    = wr_val[`POS_MAIN_VCO_OUT_DIVSEL +: 2];
          state_next.main_post_ratio_first  = wr_val[`POS_POST1 +: 3];
          state_next.main_post_ratio_second = wr_val[`POS_POST2 +: 3];
        end
        `OFS_ACTL: begin
          // lock bit and bits 5-4 are not storable
          state_next.aux_loop_enable    = wr_val[`POS_AEN];
          state_next.aux_source_select  = wr_val[`POS_FSEL];
          state_next.aux_input_prescale = wr_val[`POS_APRE +: 4];
        end
        `OFS_AFBD: state_next.aux_feedback_ratio = wr_val[`POS_AFBD +: 8];
        `OFS_ADIV: begin
          state_next.aux_vco_out_divsel    = wr_val[`POS_MAIN_VCO_OUT_DIVSEL +: 2];
          state_next.aux_post_ratio_first  = wr_val[`POS_POST1 +: 3];
          state_next.aux_post_ratio_second = wr_val[`POS_POST2 +: 3];
        end
        // write one to clear; only the low lane reaches the status bits
        `OFS_ISTS: irq_clear = state_next.w_strb[0] ? state_next.w_data[1:0] : 2'h0;
        `OFS_IMSK: state_next.irq_mask = wr_val[1:0];
        default: state_next.b_resp = `RESP_SLVERR;
      endcase
    end else if (state_reg.wr_state == clk_cfg_pkg::WR_RESP && bready) begin
      state_next.wr_state = clk_cfg_pkg::WR_IDLE;
    end
    // read captured at the address edge, answered next cycle
    if (arvalid && arready) begin
      state_next.r_data   = reg_value(state_reg, araddr);
      state_next.r_resp   = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      state_next.rd_state = clk_cfg_pkg::RD_DATA;
    end else if (rvalid && rready) begin
      state_next.rd_state = clk_cfg_pkg::RD_IDLE;
    end
    // lock gained and lost are the events; set beats a same-cycle clear
    state_next.lock_seen = aux_lock_in;
    irq_set = 2'h0;
    irq_set[`IRQ_LOCK_GAIN] = aux_lock_in && !state_reg.lock_seen;
    irq_set[`IRQ_LOCK_LOSS] = !aux_lock_in && state_reg.lock_seen;
    state_next.irq_status = (state_reg.irq_status & ~irq_clear) | irq_set;
  end

  // single register for the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= RST_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // outputs to the clock generator
  // ****************************************

  // field outputs come straight from the state register
  assign rc_trim_code           = $signed(state_reg.trim_code);
  assign main_vco_out_divsel    = state_reg.main_vco_out_divsel;
  assign main_vco_divisor       = vco_div(state_reg.main_vco_out_divsel);
  assign main_post_ratio_first  = state_reg.main_post_ratio_first;
  assign main_post_ratio_second = state_reg.main_post_ratio_second;
  assign aux_loop_enable        = state_reg.aux_loop_enable;
  assign aux_source_select      = state_reg.aux_source_select;
  assign aux_input_prescale     = state_reg.aux_input_prescale;
  assign aux_feedback_ratio     = state_reg.aux_feedback_ratio;
  assign aux_vco_out_divsel     = state_reg.aux_vco_out_divsel;
  assign aux_post_ratio_first   = state_reg.aux_post_ratio_first;
  assign aux_post_ratio_second  = state_reg.aux_post_ratio_second;
  assign aux_prescale_reserved  = (state_reg.aux_input_prescale == 4'h0) ||
                                  (state_reg.aux_input_prescale > `PRE_MAX);

  // total division of each chain; product sized to its worst case
  assign main_out_divider = 8'(int'(main_vco_divisor) *
                               int'(state_reg.main_post_ratio_first) *
                               int'(state_reg.main_post_ratio_second));
  assign aux_out_divider  = 11'(int'(pre_div(state_reg.aux_input_prescale)) *
                               int'(vco_div(state_reg.aux_vco_out_divsel)) *
                               int'(state_reg.aux_post_ratio_first) *
                               int'(state_reg.aux_post_ratio_second));

  // enable alone does not start the loop; a peripheral must ask too
  assign aux_loop_run = state_reg.aux_loop_enable && periph_clk_req;

  // clock selection; glitch-free switching is left to the analog macro
  assign aux_input_clock = state_reg.aux_source_select ? fast_osc_clk
                                                       : primary_osc_clk;
  assign aux_loop_output_clock = state_reg.aux_loop_enable ? aux_post_div_clk
                                                           : aux_input_clock;

  // level interrupt while any unmasked event is pending
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);

  // ****************************************
  // checks
  // ****************************************

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  main_post_reset_a: assert property ($rose(aresetn) |->
    main_post_ratio_first == 3'h4 && main_post_ratio_second == 3'h1)
    else $error("main post ratios not 4 and 1 after reset");

  aux_post_reset_a: assert property ($rose(aresetn) |->
    aux_post_ratio_first == 3'h4 && aux_post_ratio_second == 3'h1)
    else $error("aux post ratios not 4 and 1 after reset");

  aux_fbd_reset_a: assert property ($rose(aresetn) |->
    aux_feedback_ratio == 8'd150 && aux_input_prescale == 4'h1)
    else $error("aux feedback or prescale wrong after reset");

  trim_write_a: assert property (
    (awvalid && awready && wvalid && wready && awaddr == 8'h00 && wstrb[0]) |=>
    rc_trim_code == $signed($past(wdata[5:0])) && bvalid)
    else $error("trim write not reflected as signed code");

  trim_extreme_a: assert property (
    (state_reg.trim_code == 6'h20 |-> rc_trim_code < 6'sh00) and
    (state_reg.trim_code == 6'h1F |-> rc_trim_code > 6'sh00))
    else $error("most negative trim code misread");

  vco_decode_a: assert property (
    (main_vco_out_divsel == 2'b11 |-> main_vco_divisor == 3'h1) and
    (main_vco_out_divsel == 2'b00 |-> main_vco_divisor == 3'h4))
    else $error("main vco divider decode wrong");

  aux_bypass_a: assert property (
    !aux_loop_enable |-> aux_loop_output_clock == aux_input_clock)
    else $error("bypass does not pass input clock");

  aux_source_a: assert property (
    aux_source_select |-> aux_input_clock == fast_osc_clk)
    else $error("fast oscillator not routed to aux input");

  aux_start_a: assert property (
    aux_loop_enable && !periph_clk_req |-> !aux_loop_run)
    else $error("aux loop started without a clock request");

  lock_read_a: assert property (
    (arvalid && arready && araddr == 8'h08) |=>
    rvalid && rdata[14] == $past(aux_lock_in, 2))
    else $error("lock status readback wrong");

  reserved_zero_a: assert property (
    (arvalid && arready && araddr == 8'h08) |=> rdata[5:4] == 2'h0 && rdata[31:16] == 16'h0)
    else $error("reserved bits not zero");

  prescale_flag_a: assert property (
    aux_input_prescale == 4'h9 |-> aux_prescale_reserved && aux_out_divider ==
    11'(int'(vco_div(aux_vco_out_divsel)) * int'(aux_post_ratio_first) *
        int'(aux_post_ratio_second)))
    else $error("reserved prescale not flagged or not treated as one");

  main_total_a: assert property (
    (main_vco_out_divsel == 2'b11 && main_post_ratio_second == 3'h1) |->
    main_out_divider == {5'h00, main_post_ratio_first})
    else $error("main total divider mismatch");

  lock_irq_a: assert property (
    $rose(aux_lock_in) && state_reg.irq_mask[0] |=> irq)
    else $error("lock event did not raise interrupt");

  write_seen_c: cover property (awvalid && awready && wvalid && wready);
  unmapped_c:   cover property (bvalid && bresp == `RESP_SLVERR);
  lock_irq_c:   cover property ($rose(aux_lock_in) ##1 irq);
  aux_run_c:    cover property (aux_loop_run);

endmodule : clk_cfg_regs
`default_nettype wire

// ===== verif/pll_divider_and_aux_pll_config_bench.sv
`default_nettype none
module pll_divider_and_aux_pll_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, fast_osc_clk = 1'b0, primary_osc_clk = 1'b0;
  logic        aux_post_div_clk = 1'b0, periph_clk_req = 1'b0, aux_lock_in = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, main_out_divider, aux_feedback_ratio;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hF, aux_input_prescale;
  logic        awready, wready, bvalid, arready, rvalid, irq, aux_loop_enable, aux_loop_run;
  logic        aux_source_select, aux_prescale_reserved, aux_input_clock, aux_loop_output_clock;
  logic [1:0]  bresp, rresp, main_vco_out_divsel, aux_vco_out_divsel, resp;
  logic [2:0]  main_vco_divisor, main_post_ratio_first, main_post_ratio_second;
  logic [2:0]  aux_post_ratio_first, aux_post_ratio_second;
  logic [10:0] aux_out_divider;
  logic signed [5:0] rc_trim_code;
  int          n_errors = 0, tests_run = 0;
  clk_cfg_regs uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .fast_osc_clk(fast_osc_clk), .primary_osc_clk(primary_osc_clk),
    .aux_post_div_clk(aux_post_div_clk), .periph_clk_req(periph_clk_req),
    .aux_lock_in(aux_lock_in), .rc_trim_code(rc_trim_code),
    .main_vco_out_divsel(main_vco_out_divsel), .main_vco_divisor(main_vco_divisor),
    .main_post_ratio_first(main_post_ratio_first),
    .main_post_ratio_second(main_post_ratio_second), .main_out_divider(main_out_divider),
    .aux_loop_enable(aux_loop_enable), .aux_loop_run(aux_loop_run),
    .aux_source_select(aux_source_select), .aux_input_prescale(aux_input_prescale),
    .aux_prescale_reserved(aux_prescale_reserved), .aux_feedback_ratio(aux_feedback_ratio),
    .aux_vco_out_divsel(aux_vco_out_divsel), .aux_post_ratio_first(aux_post_ratio_first),
    .aux_post_ratio_second(aux_post_ratio_second), .aux_out_divider(aux_out_divider),
    .aux_input_clock(aux_input_clock), .aux_loop_output_clock(aux_loop_output_clock),
    .irq(irq)
  );
  // 25 MHz bus clock
  always #20 aclk = ~aclk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // both channels offered together, each dropped once taken; trailing edge avoids re-entry race
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
    if (n >= 64) n_errors++;
  endtask : wr
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    if (n >= 64) n_errors++;
  endtask : rdw
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rdw(a, rd, resp);
    check(resp, 2'h0);
    check(rd, e);
  endtask : rc
  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    check(irq, 1'b0);
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0041);
    rc(8'h08, 32'h0001);
    rc(8'h0C, 32'h0096);
    rc(8'h10, 32'h0041);
    check(main_out_divider, 32'h10);
    check(aux_feedback_ratio, 8'h96);
  endtask : t_reset
  task automatic t_trim;
    wr(8'h00, 16'h0020, resp);
    check($unsigned(rc_trim_code), 32'h20);
    check(rc_trim_code < 0, 1'b1);
    wr(8'h00, 16'h001F, resp);
    check($unsigned(rc_trim_code), 32'h1F);
    wr(8'h00, 16'hFFFF, resp);
    rc(8'h00, 32'h003F);
  endtask : t_trim
  // posts 7 and 3 so every vco code gives a distinct total
  task automatic t_div;
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 16'(c) << 8 | 16'h0073, resp);
      wr(8'h10, 16'(c) << 8 | 16'h0073, resp);
      check(main_vco_out_divsel, c);
      check(aux_vco_out_divsel, c);
      check(main_vco_divisor, 4 - c);
      check(main_out_divider, 21 * (4 - c));
      check(aux_out_divider, 21 * (4 - c));
    end
    wr(8'h04, 16'hFFFF, resp);
    rc(8'h04, 32'h0377);
    // low lane only: the vco select in the upper lane must survive
    wstrb <= 4'h1;
    wr(8'h04, 16'h0021, resp);
    wstrb <= 4'hF;
    rc(8'h04, 32'h0321);
    check(main_post_ratio_second, 3'h1);
  endtask : t_div
  // both ends of the legal feedback range; upper lane is unimplemented
  task automatic t_fbd;
    wr(8'h0C, 16'h00C8, resp);
    check(aux_feedback_ratio, 8'hC8);
    wr(8'h0C, 16'hFF10, resp);
    rc(8'h0C, 32'h0010);
    check(aux_feedback_ratio, 8'h10);
  endtask : t_fbd
  task automatic t_aux;
    for (int p = 0; p < 16; p++) begin
      wr(8'h08, 16'h8100 | 16'(p), resp);
      rc(8'h08, 32'h8100 | p);
      check(aux_input_prescale, p);
      check(aux_prescale_reserved, p == 0 || p > 8);
      check(aux_out_divider, (p == 0 || p > 8) ? 21 : 21 * p);
    end
    fast_osc_clk <= 1'b1;
    @(posedge aclk);
    check(aux_input_clock, 1'b1);
    check(aux_source_select, 1'b1);
    check(aux_loop_enable, 1'b1);
    check(aux_loop_output_clock, 1'b0);
    check(aux_loop_run, 1'b0);
    periph_clk_req <= 1'b1;
    aux_post_div_clk <= 1'b1;
    @(posedge aclk);
    check(aux_loop_run, 1'b1);
    check(aux_loop_output_clock, 1'b1);
    wr(8'h08, 16'h0001, resp);
    check(aux_input_clock, 1'b0);
    check(aux_loop_run, 1'b0);
    primary_osc_clk <= 1'b1;
    aux_post_div_clk <= 1'b0;
    @(posedge aclk);
    check(aux_loop_output_clock, 1'b1);
  endtask : t_aux
  // only lock gain is unmasked, so lock loss must stay silent
  task automatic t_lock;
    wr(8'h18, 16'h0001, resp);
    aux_lock_in <= 1'b1;
    repeat (3) @(posedge aclk);
    check(irq, 1'b1);
    rc(8'h08, 32'h4001);
    rc(8'h14, 32'h0001);
    wr(8'h14, 16'h0001, resp);
    check(irq, 1'b0);
    aux_lock_in <= 1'b0;
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
    rc(8'h14, 32'h0002);
    rc(8'h08, 32'h0001);
    wr(8'h1C, 16'hFFFF, resp);
    check(resp, 2'h2);
    rdw(8'h1C, rd, resp);
    check(resp, 2'h2);
    check(rd, 32'h0);
  endtask : t_lock
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_trim();
    t_div();
    t_fbd();
    t_aux();
    t_lock();
    finish_test();
  end
  initial begin
    #(40 * 5000);
    n_errors++;
    finish_test();
  end
endmodule : pll_divider_and_aux_pll_config_bench
`default_nettype wire
